// >>> design/fifo_service_defs.svh
`ifndef FIFO_SERVICE_DEFS_SVH
`define FIFO_SERVICE_DEFS_SVH

// ---------------------------------------------------------------
// Pass-through vector layout
// ---------------------------------------------------------------
`define VEC_TOP_PATTERN    4'h8
`define VEC_ID_NO_AUTO     4'h6
`define VEC_ID_HI_ZERO     2'h0
`define VEC_FIELD_ZERO     8'h00

// ---------------------------------------------------------------
// FIFO chunking
// ---------------------------------------------------------------
`define FIFO_CHUNK_BYTES   32
`define STATUS_PAD         15'h0000
`define ACC_RESET          32'h0000_0000

`endif

// >>> design/fifo_service_pkg.sv
package fifo_service_pkg;

	typedef enum logic [3:0] {
		ST_IDLE, ST_RD_GIS, ST_RD_ISR, ST_VEC, ST_RX_CNT, ST_RX_RD, ST_RX_PUSH,
		ST_RX_STAT, ST_TX_REQ, ST_TX_FILL, ST_TX_WR, ST_TX_CMD, ST_NEXT
	} engine_state_e;

	typedef struct packed {
		logic [15:0]       gis_addr;
		logic [3:0][15:0]  isr_addr;
		logic [1:0][15:0]  rx_fifo_addr;
		logic [1:0][15:0]  tx_fifo_addr;
		logic [1:0][15:0]  cmd_addr;
		logic [1:0][15:0]  rbc_addr;
		logic [7:0]        rpf_bit;
		logic [7:0]        rme_bit;
		logic [7:0]        xpr_bit;
		logic [7:0]        xtf_bit;
		logic [7:0]        xme_bit;
		logic [5:0]        rx_threshold;
		logic [1:0]        auto_en;
	} local_bus_config_s;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] passthrough_irq_vector;
	} irq_entry_s;

	typedef struct packed {
		logic        is_status;
		logic [31:0] data;
	} rx_word_s;

	typedef struct packed {
		logic        last;
		logic [2:0]  nbytes;
		logic [31:0] data;
	} tx_word_s;

endpackage

// >>> design/pair_buffer.sv
`timescale 1ns/1ns

module pair_buffer #(
	parameter int W = 32
) (
	input  wire logic          ref_clk,    // Clock
	input  wire logic          nrst,       // Async reset, active low
	input  wire logic          in_valid,   // Word offered
	output logic               in_ready,   // Room for a word
	input  wire logic [W-1:0]  in_data,    // Word in
	output logic               out_valid,  // Word held
	input  wire logic          out_ready,  // Drain accepts
	output logic [W-1:0]       out_data    // Word out
);

	logic [1:0][W-1:0] mem_r;
	logic              wr_ptr_r;
	logic              rd_ptr_r;
	logic [1:0]        count_r;
	logic              push;
	logic              pop;

	assign in_ready  = (count_r != 2'd2);
	assign out_valid = (count_r != 2'd0);
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
			mem_r <= '0;
		else if (push)
			mem_r[wr_ptr_r] <= in_data;

	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r  <= 2'd0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= ~wr_ptr_r;
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
		end

endmodule // pair_buffer

// >>> design/byte_store.sv
`timescale 1ns/1ns

module byte_store #(
	parameter int WORDS = 8
) (
	input  wire logic                       ref_clk,  // Clock
	input  wire logic                       nrst,     // Async reset, active low
	input  wire logic                       wr_en,    // Write one word
	input  wire logic [$clog2(WORDS)-1:0]   wr_idx,   // Word index
	input  wire logic [31:0]                wr_data,  // Word data
	input  wire logic [$clog2(WORDS)+1:0]   rd_idx,   // Byte index
	output logic [7:0]                      rd_byte   // Byte at index
);

	logic [WORDS-1:0][31:0] mem_r;

	assign rd_byte = mem_r[rd_idx[$clog2(WORDS)+1:2]][rd_idx[1:0]*8 +: 8];

	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
			mem_r <= '0;
		else if (wr_en)
			mem_r[wr_idx] <= wr_data;

endmodule // byte_store

// >>> design/fifo_service_engine.sv
// Summary of operation
// (R1) Vector holds id, global status, interrupt status and local status fields.
// (R2) Vector bits 31..28 are 1000, id 27..24, global 23..16, status 15..8.
// (R3) With automatic processing, low byte copies the local status register.
// (R4) Without automatic processing, id is 0110 and all status fields zero.
// (R5) Status byte in vector; ids 0..3 mark channel A/B status regs.
// (R6) Global status field carries the peripheral global status register.
// (R7) Software matches receive threshold to the peripheral's own threshold.
// (R8) Receive pool full: read threshold bytes, pack dwords, hand to receive DMA.
// (R9) Dwords are offered back to back so DMA can burst them.
// (R10) Message end: read byte count, fetch exactly the remaining bytes.
// (R11) A status word after the data reports the packet's valid bytes.
// (R12) Transmit pool ready: ask transmit DMA to fetch data into local store.
// (R13) At 32 stored bytes write them out, then issue transmit-frame command.
// (R14) Each later transmit pool ready fetches and writes the next chunk.
// (R15) At packet end write only valid bytes, then frame and message-end commands.
// (R16) Mask register blocks each peripheral source; masked ones make no vector.
// (R17) Unmasked interrupts send a vector to the interrupt queue base address.
// (R18) Only FIFO bits are acted on; with automatic processing all status forwarded unchanged.
`timescale 1ns/1ns
`include "fifo_service_defs.svh"

module fifo_service_engine
	import fifo_service_pkg::*;
#(
	parameter int CHUNK_BYTES = `FIFO_CHUNK_BYTES
) (
	input  wire logic               ref_clk,              // Clock, 100 MHz
	input  wire logic               nrst,                 // Async reset, active low
	input  wire local_bus_config_s  cfg,                  // Peripheral map and bits
	input  wire logic [31:0]        peripheral_irq_mask,  // One byte per status reg
	input  wire logic [31:0]        irq_queue_base,       // Vector target address
	input  wire logic [7:0]         local_status,         // Own status register
	input  wire logic               lb_irq,               // Peripheral interrupt level
	output logic                    lb_req,               // Bus access request
	output logic                    lb_we,                // Access is a write
	output logic [15:0]             lb_addr,              // Peripheral address
	output logic [7:0]              lb_wdata,             // Write byte
	input  wire logic               lb_ack,               // Access done
	input  wire logic [7:0]         lb_rdata,             // Read byte, with ack
	output logic                    irq_valid,            // Vector offered
	input  wire logic               irq_ready,            // Queue accepts
	output irq_entry_s              irq_entry,            // Address and vector
	output logic                    rx_valid,             // Receive word offered
	input  wire logic               rx_ready,             // Receive DMA accepts
	output rx_word_s                rx_word,              // Data or status word
	output logic                    tx_fetch_req,         // Pulse: fetch next chunk
	input  wire logic               tx_valid,             // Transmit word offered
	output logic                    tx_ready,             // Room for transmit word
	input  wire tx_word_s           tx_word,              // Transmit DMA word
	output logic                    busy                  // Engine not idle
);

	localparam int WORDS = CHUNK_BYTES / 4;
	localparam int WIW   = $clog2(WORDS);

	if (CHUNK_BYTES < 8 || CHUNK_BYTES > 32 || (CHUNK_BYTES & (CHUNK_BYTES - 1)) != 0)
		$error("CHUNK_BYTES must be a power of two from 8 to 32");

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	engine_state_e   state_r;
	logic [1:0]      idx_r;
	logic [7:0]      gis_r;
	logic [7:0]      isr_r;
	logic [5:0]      rx_left_r;
	logic [1:0]      lane_r;
	logic [31:0]     acc_r;
	logic            rx_end_r;
	logic [15:0]     pkt_bytes_r;
	logic [5:0]      tx_fill_r;
	logic [5:0]      tx_pos_r;
	logic            tx_end_r;

	// ---------------------------------------------------------------
	// Decode of the latched status byte
	// ---------------------------------------------------------------
	logic            ch;
	logic            auto_on;
	logic [7:0]      act_bits;
	logic            do_rme;
	logic            do_rpf;
	logic            do_xpr;
	engine_state_e   after_vec;
	engine_state_e   after_rx;
	logic [5:0]      rem_bytes;
	logic            acked;

	assign ch       = idx_r[1];
	assign auto_on  = cfg.auto_en[ch];
	assign act_bits = isr_r & ~peripheral_irq_mask[idx_r*8 +: 8];  // [R16]
	assign do_rme   = auto_on && ((act_bits & cfg.rme_bit) != 8'h00);  // [R18]
	assign do_rpf   = auto_on && ((act_bits & cfg.rpf_bit) != 8'h00);  // [R18]
	assign do_xpr   = auto_on && ((act_bits & cfg.xpr_bit) != 8'h00);  // [R18]
	assign acked    = lb_req && lb_ack;
	assign busy     = (state_r != ST_IDLE);
	assign after_vec = do_rme ? ST_RX_CNT : do_rpf ? ST_RX_RD : do_xpr ? ST_TX_REQ : ST_NEXT;
	assign after_rx  = do_xpr ? ST_TX_REQ : ST_NEXT;

	// Bytes left in peripheral FIFO after full chunks were taken
	assign rem_bytes = (lb_rdata != 8'h00 && (lb_rdata[4:0] & 5'(CHUNK_BYTES - 1)) == 5'h00)
		? 6'(CHUNK_BYTES) : {1'b0, lb_rdata[4:0] & 5'(CHUNK_BYTES - 1)};  // [R10]

	// ---------------------------------------------------------------
	// Vector assembly and queue
	// ---------------------------------------------------------------
	irq_entry_s vec_in;
	logic       vec_push;
	logic       vec_room;

	assign vec_in.addr = irq_queue_base;  // [R17]
	assign vec_in.passthrough_irq_vector = auto_on  // [R1] [R2] [R3] [R5] [R6] [R18]
		? {`VEC_TOP_PATTERN, `VEC_ID_HI_ZERO, idx_r, gis_r, isr_r, local_status}
		: {`VEC_TOP_PATTERN, `VEC_ID_NO_AUTO,
			`VEC_FIELD_ZERO, `VEC_FIELD_ZERO, `VEC_FIELD_ZERO};  // [R4]
	assign vec_push = (state_r == ST_VEC) && (act_bits != 8'h00);  // [R16] [R17]

	pair_buffer #(.W($bits(irq_entry_s))) u_irq_buf (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (vec_push),
		.in_ready  (vec_room),
		.in_data   (vec_in),
		.out_valid (irq_valid),
		.out_ready (irq_ready),
		.out_data  (irq_entry)
	);

	// ---------------------------------------------------------------
	// Receive word path
	// ---------------------------------------------------------------
	rx_word_s rx_in;
	logic     rx_push;
	logic     rx_room;

	assign rx_push = (state_r == ST_RX_PUSH) || (state_r == ST_RX_STAT);  // [R9]
	assign rx_in.is_status = (state_r == ST_RX_STAT);
	assign rx_in.data = (state_r == ST_RX_STAT) ? {`STATUS_PAD, 1'b1, pkt_bytes_r}
		: acc_r;  // [R11]
	pair_buffer #(.W($bits(rx_word_s))) u_rx_buf (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (rx_push),
		.in_ready  (rx_room),
		.in_data   (rx_in),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_word)
	);

	// ---------------------------------------------------------------
	// Transmit word path and local store
	// ---------------------------------------------------------------
	tx_word_s tx_out;
	logic     tx_have;
	logic     tx_take;
	logic [7:0] tx_byte;
	logic [5:0] tx_fill_nxt;

	assign tx_take     = (state_r == ST_TX_FILL) && tx_have;
	assign tx_fill_nxt = tx_fill_r + (tx_out.last ? {3'd0, tx_out.nbytes} : 6'd4);  // [R15]
	assign tx_fetch_req = (state_r == ST_TX_REQ);  // [R12] [R14]
	pair_buffer #(.W($bits(tx_word_s))) u_tx_buf (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (tx_word),
		.out_valid (tx_have),
		.out_ready (state_r == ST_TX_FILL),
		.out_data  (tx_out)
	);

	byte_store #(.WORDS(WORDS)) u_tx_store (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.wr_en   (tx_take),
		.wr_idx  (tx_fill_r[WIW+1:2]),
		.wr_data (tx_out.data),
		.rd_idx  (tx_pos_r[WIW+1:0]),
		.rd_byte (tx_byte)
	);

	// ---------------------------------------------------------------
	// Local bus access
	// ---------------------------------------------------------------
	always_comb
	begin
		lb_req   = 1'b1;
		lb_we    = 1'b0;
		lb_addr  = 16'h0000;
		lb_wdata = 8'h00;
		case (state_r)
			ST_RD_GIS: lb_addr = cfg.gis_addr;
			ST_RD_ISR: lb_addr = cfg.isr_addr[idx_r];
			ST_RX_CNT: lb_addr = cfg.rbc_addr[ch];  // [R10]
			ST_RX_RD:  lb_addr = cfg.rx_fifo_addr[ch];  // [R8]
			ST_TX_WR:
			begin
				lb_addr  = cfg.tx_fifo_addr[ch];  // [R13]
				lb_we    = 1'b1;
				lb_wdata = tx_byte;
			end
			ST_TX_CMD:
			begin
				lb_addr  = cfg.cmd_addr[ch];
				lb_we    = 1'b1;
				lb_wdata = cfg.xtf_bit | (tx_end_r ? cfg.xme_bit : 8'h00);  // [R13] [R15]
			end
			default: lb_req = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
			state_r <= ST_IDLE;
		else
			case (state_r)
				ST_IDLE:
					if (lb_irq)
						state_r <= ST_RD_GIS;
				ST_RD_GIS:
					if (acked)
						state_r <= (lb_rdata != 8'h00) ? ST_RD_ISR : ST_IDLE;
				ST_RD_ISR:
					if (acked)
						state_r <= ST_VEC;
				ST_VEC:
					if (!vec_push || vec_room)
						state_r <= after_vec;
				ST_RX_CNT:
					if (acked)
						state_r <= (rem_bytes == 6'd0) ? ST_RX_STAT : ST_RX_RD;
				ST_RX_RD:
					if (acked && (lane_r == 2'd3 || rx_left_r == 6'd1))
						state_r <= ST_RX_PUSH;
				ST_RX_PUSH:
					if (rx_room)
					begin
						if (rx_left_r != 6'd0)
							state_r <= ST_RX_RD;  // [R9]
						else if (rx_end_r)
							state_r <= ST_RX_STAT;  // [R11]
						else
							state_r <= after_rx;
					end
				ST_RX_STAT:
					if (rx_room)
						state_r <= after_rx;
				ST_TX_REQ:
					state_r <= ST_TX_FILL;
				ST_TX_FILL:
					if (tx_take && (tx_out.last || tx_fill_nxt >= 6'(CHUNK_BYTES)))
						state_r <= ST_TX_WR;  // [R13]
				ST_TX_WR:
					if (acked && (tx_pos_r + 6'd1 >= tx_fill_r))
						state_r <= ST_TX_CMD;
				ST_TX_CMD:
					if (acked)
						state_r <= ST_NEXT;
				ST_NEXT:
					state_r <= (idx_r == 2'd3) ? ST_IDLE : ST_RD_ISR;
				default:
					state_r <= ST_IDLE;
			endcase

	// ---------------------------------------------------------------
	// Status capture
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			gis_r <= 8'h00;
			isr_r <= 8'h00;
			idx_r <= 2'd0;
		end
		else
		begin
			if (state_r == ST_RD_GIS && acked)
			begin
				gis_r <= lb_rdata;  // [R6]
				idx_r <= 2'd0;
			end
			if (state_r == ST_RD_ISR && acked)
				isr_r <= lb_rdata;  // [R5]
			if (state_r == ST_NEXT)
				idx_r <= idx_r + 2'd1;
		end

	// ---------------------------------------------------------------
	// Receive packing
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			rx_left_r   <= 6'd0;
			lane_r      <= 2'd0;
			acc_r       <= `ACC_RESET;
			rx_end_r    <= 1'b0;
			pkt_bytes_r <= 16'h0000;
		end
		else
			case (state_r)
				ST_VEC:
				begin
					rx_end_r  <= do_rme;
					rx_left_r <= cfg.rx_threshold;  // [R7] [R8]
				end
				ST_RX_CNT:
					if (acked)
						rx_left_r <= rem_bytes;  // [R10]
				ST_RX_RD:
					if (acked)
					begin
						acc_r[lane_r*8 +: 8] <= lb_rdata;  // [R8]
						lane_r      <= lane_r + 2'd1;
						rx_left_r   <= rx_left_r - 6'd1;
						pkt_bytes_r <= pkt_bytes_r + 16'd1;
					end
				ST_RX_PUSH:
					if (rx_room)
					begin
						lane_r <= 2'd0;
						acc_r  <= `ACC_RESET;
					end
				ST_RX_STAT:
					if (rx_room)
						pkt_bytes_r <= 16'h0000;
				default:
					lane_r <= lane_r;
			endcase

	// ---------------------------------------------------------------
	// Transmit chunk
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			tx_fill_r <= 6'd0;
			tx_pos_r  <= 6'd0;
			tx_end_r  <= 1'b0;
		end
		else
			case (state_r)
				ST_TX_REQ:
				begin
					tx_fill_r <= 6'd0;
					tx_pos_r  <= 6'd0;
					tx_end_r  <= 1'b0;
				end
				ST_TX_FILL:
					if (tx_take)
					begin
						tx_fill_r <= tx_fill_nxt;
						tx_end_r  <= tx_out.last;  // [R15]
					end
				ST_TX_WR:
					if (acked)
						tx_pos_r <= tx_pos_r + 6'd1;
				default:
					tx_pos_r <= tx_pos_r;
			endcase

endmodule // fifo_service_engine

// >>> bench/fifo_service_engine_properties.sv
`timescale 1ns/1ns

module fifo_service_engine_properties
	import fifo_service_pkg::*;
(
	input wire logic        ref_clk,        // Clock
	input wire logic        nrst,           // Reset, active low
	input wire logic [31:0] irq_queue_base, // Queue address
	input wire logic [7:0]  local_status,   // Own status
	input wire logic        lb_req,         // Bus request
	input wire logic        lb_we,          // Write
	input wire logic [15:0] lb_addr,        // Address
	input wire logic [7:0]  lb_wdata,       // Write byte
	input wire logic        lb_ack,         // Done
	input wire logic        irq_valid,      // Vector offered
	input wire logic        irq_ready,      // Vector taken
	input wire irq_entry_s  irq_entry,      // Vector
	input wire logic        rx_valid,       // Word offered
	input wire logic        rx_ready,       // Word taken
	input wire rx_word_s    rx_word,        // Word
	input wire logic        tx_fetch_req,   // Fetch pulse
	input wire logic        busy            // Not idle
);
	logic [31:0] vec;
	assign vec = irq_entry.passthrough_irq_vector;

	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_wait;
		lb_req && !lb_ack;
	endsequence
	sequence s_held;
		lb_req && $stable(lb_addr) && $stable(lb_we) && $stable(lb_wdata);
	endsequence

	a_bus_hold: assert property (s_wait |=> s_held)
		else $error("bus request changed before ack");
	a_vec_top: assert property (irq_valid |-> vec[31:28] == 4'h8)
		else $error("vector top bits wrong");
	a_vec_addr: assert property (irq_valid |-> irq_entry.addr == irq_queue_base)
		else $error("vector address wrong");
	a_vec_plain: assert property (irq_valid && vec[27:24] == 4'h6 |-> vec[23:0] == 24'h0)
		else $error("plain vector fields not zero");
	a_vec_id: assert property (irq_valid
		|-> vec[27:24] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h6})
		else $error("vector id out of set");
	a_vec_local: assert property (irq_valid && vec[27:24] != 4'h6
		|-> vec[7:0] == local_status)
		else $error("local status not copied");
	a_vec_hold: assert property (irq_valid && !irq_ready |=> irq_valid && $stable(irq_entry))
		else $error("vector dropped while stalled");
	a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
		else $error("rx word dropped while stalled");
	a_fetch_pulse: assert property (tx_fetch_req |=> !tx_fetch_req)
		else $error("fetch request longer than one cycle");
	a_idle_quiet: assert property (!busy |-> !lb_req && !tx_fetch_req)
		else $error("activity while idle");
	a_stat_mark: assert property (rx_valid && rx_word.is_status
		|-> rx_word.data[31:16] == 16'h0001)
		else $error("status word marker wrong");
endmodule // fifo_service_engine_properties

bind fifo_service_engine fifo_service_engine_properties chk (.ref_clk, .nrst, .irq_queue_base,
	.local_status, .lb_req, .lb_we, .lb_addr, .lb_wdata, .lb_ack, .irq_valid, .irq_ready,
	.irq_entry, .rx_valid, .rx_ready, .rx_word, .tx_fetch_req, .busy);

// >>> bench/periph_model.sv
`timescale 1ns/1ns

module periph_model (
	input wire logic        ref_clk,  // Clock
	input wire logic        nrst,     // Reset, active low
	input wire logic [1:0]  lat,      // Ack delay
	input wire logic        irq_set,  // Raise interrupt
	input wire logic        lb_req,   // Request
	input wire logic        lb_we,    // Write
	input wire logic [15:0] lb_addr,  // Address
	input wire logic [7:0]  lb_wdata, // Write byte
	output logic            lb_ack,   // Done
	output logic [7:0]      lb_rdata, // Read byte
	output logic            lb_irq    // Interrupt level
);
	logic [7:0] regs [256];
	logic [7:0] seq_r;
	logic [7:0] last_r;
	logic [1:0] cnt_r;
	logic [7:0] txq [$];
	logic [7:0] cmdq [$];
	logic [7:0] a;
	assign a = lb_addr[7:0];
	assign lb_ack = lb_req && (cnt_r == lat);
	// Released bus shows inverse of last byte
	assign lb_rdata = !lb_ack ? ~last_r : (a == 8'h00) ? seq_r : regs[a];

	always @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			cnt_r <= 2'h0;
			seq_r <= 8'h00;
			last_r <= 8'h00;
			lb_irq <= 1'b0;
		end
		else
		begin
			if (irq_set)
				lb_irq <= 1'b1;
			cnt_r <= (lb_req && !lb_ack) ? cnt_r + 2'h1 : 2'h0;
			if (lb_ack)
			begin
				last_r <= lb_rdata;
				if (lb_we && a == 8'h01)
					txq.push_back(lb_wdata);
				else if (lb_we && a == 8'h02)
					cmdq.push_back(lb_wdata);
				else if (!lb_we && a == 8'h00)
					seq_r <= seq_r + 8'h01; // Each read of receive FIFO address 00 (channel A) returns the next byte of an incrementing sequence
				else if (!lb_we && a >= 8'h10 && a <= 8'h14)
				begin
					regs[a] <= 8'h00;
					if (a == 8'h10)
						lb_irq <= 1'b0;
				end
			end
		end
endmodule // periph_model

// >>> bench/fifo_service_engine_tb.sv
`timescale 1ns/1ns

module fifo_service_engine_tb;
	import fifo_service_pkg::*;
	logic ref_clk = 0, nrst = 0, irq_set = 0, irq_ready = 1, rx_ready = 1, tx_valid = 0;
	logic [1:0] lat = 2'h0;
	local_bus_config_s cfg;
	logic [31:0] peripheral_irq_mask = 32'h0, irq_queue_base = 32'h0000_1000;
	logic [7:0] local_status = 8'hA5, lb_wdata, lb_rdata;
	logic [15:0] lb_addr;
	logic lb_irq, lb_req, lb_we, lb_ack, irq_valid, rx_valid, tx_fetch_req, tx_ready, busy;
	irq_entry_s irq_entry;
	rx_word_s rx_word;
	tx_word_s tx_word = '0;
	int bad_count = 0, check_count = 0, cyc = 0;
	logic [31:0] vq [$];
	rx_word_s rq [$];
	tx_word_s txw [$];

	always #5 ref_clk = ~ref_clk;

	fifo_service_engine uut (.ref_clk, .nrst, .cfg, .peripheral_irq_mask, .irq_queue_base,
		.local_status, .lb_irq, .lb_req, .lb_we, .lb_addr, .lb_wdata, .lb_ack, .lb_rdata,
		.irq_valid, .irq_ready, .irq_entry, .rx_valid, .rx_ready, .rx_word, .tx_fetch_req,
		.tx_valid, .tx_ready, .tx_word, .busy);
	periph_model pm (.ref_clk, .nrst, .lat, .irq_set, .lb_req, .lb_we, .lb_addr, .lb_wdata,
		.lb_ack, .lb_rdata, .lb_irq);

	always @(posedge ref_clk)
	begin
		cyc++;
		if (irq_valid && irq_ready)
			vq.push_back(irq_entry.passthrough_irq_vector);
		if (rx_valid && rx_ready)
			rq.push_back(rx_word);
		if (cyc == 20000)
		begin
			bad_count++;
			finish_test;
		end
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask

	function automatic logic [31:0] wd(input int b);
		return {8'(b + 3), 8'(b + 2), 8'(b + 1), 8'(b)};
	endfunction

	function automatic logic [31:0] vexp(input logic [3:0] id, input logic [7:0] g, s);
		return {4'h8, id, g, s, local_status};
	endfunction

	// Load status, raise interrupt, feed chunks, wait for idle
	task automatic run(input logic [7:0] g, input logic [31:0] isr, input int stall);
		int n;
		@(negedge ref_clk);
		pm.regs[8'h10] = g;
		for (int i = 0; i < 4; i++)
			pm.regs[8'h11 + i] = isr[8 * i +: 8];
		irq_set = 1;
		rx_ready = (stall == 0);
		irq_ready = (stall == 0);
		@(negedge ref_clk);
		irq_set = 0;
		n = 0;
		while (txw.size() > 0 && tx_fetch_req !== 1'b1 && n < 500)
		begin
			@(negedge ref_clk);
			n++;
		end
		while (txw.size() > 0)
		begin
			tx_valid = 1;
			tx_word = txw.pop_front();
			while (tx_ready !== 1'b1)
				@(negedge ref_clk);
			@(negedge ref_clk);
		end
		tx_valid = 0;
		repeat (stall) @(negedge ref_clk);
		rx_ready = 1;
		irq_ready = 1;
		n = 0;
		while ((busy !== 1'b0 || lb_irq !== 1'b0) && n < 2000)
		begin
			@(negedge ref_clk);
			n++;
		end
		repeat (3) @(negedge ref_clk);
	endtask

	initial
	begin
		cfg = '0;
		cfg.gis_addr = 16'h0010;
		cfg.isr_addr = {16'h0014, 16'h0013, 16'h0012, 16'h0011};
		cfg.rx_fifo_addr = {16'h0040, 16'h0000};
		cfg.tx_fifo_addr = {16'h0041, 16'h0001};
		cfg.cmd_addr = {16'h0042, 16'h0002};
		cfg.rbc_addr = {16'h0043, 16'h0003};
		cfg = '{cfg.gis_addr, cfg.isr_addr, cfg.rx_fifo_addr, cfg.tx_fifo_addr, cfg.cmd_addr,
			cfg.rbc_addr, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 6'h04, 2'h2};
		repeat (4) @(negedge ref_clk);
		nrst = 1;
		// Channel A without automatic processing
		run(8'h01, 32'h0000_0001, 0);
		chk(vq.size(), 1);
		chk(vq.pop_front(), 32'h8600_0000);
		chk(rq.size(), 0);
		$display("test plain done");
		// Pool full, non-FIFO bit passed, masked register silent
		cfg.auto_en = 2'h3;
		peripheral_irq_mask = 32'h00FF_0000;
		run(8'h05, 32'h0020_8001, 0);
		chk(vq.size(), 2);
		chk(vq.pop_front(), vexp(4'h0, 8'h05, 8'h01));
		chk(vq.pop_front(), vexp(4'h1, 8'h05, 8'h80));
		chk(rq.pop_front(), {1'b0, wd(0)});
		$display("test pool done");
		// Message end with slow bus and stalled queues
		lat = 2'h2;
		pm.regs[8'h03] = 8'h06;
		run(8'h01, 32'h0000_0002, 30);
		chk(vq.pop_front(), vexp(4'h0, 8'h01, 8'h02));
		chk(rq.size(), 3);
		chk(rq.pop_front(), {1'b0, wd(4)});
		chk(rq.pop_front(), {1'b0, 32'h0000_0908});
		chk(rq.pop_front(), {1'b1, 32'h0001_000A});
		$display("test end done");
		// Full chunk then short last chunk
		lat = 2'h1;
		for (int k = 0; k < 8; k++)
			txw.push_back('{1'b0, 3'h0, wd(4 * k)});
		run(8'h01, 32'h0000_0004, 0);
		chk(vq.pop_front(), vexp(4'h0, 8'h01, 8'h04));
		chk(pm.txq.size(), 32);
		for (int k = 0; k < 32; k++)
			chk(pm.txq[k], k);
		chk(pm.cmdq.pop_front(), 8'h08);
		pm.txq.delete();
		txw.push_back('{1'b0, 3'h0, wd(32)});
		txw.push_back('{1'b1, 3'h3, wd(36)});
		run(8'h01, 32'h0000_0004, 0);
		chk(vq.pop_front(), vexp(4'h0, 8'h01, 8'h04));
		chk(pm.txq.size(), 7);
		for (int k = 0; k < 7; k++)
			chk(pm.txq[k], 32 + k);
		chk(pm.cmdq.pop_front(), 8'h18);
		$display("test tx done");
		finish_test;
	end
endmodule // fifo_service_engine_tb
